// ==== src/slcd_regs.vh ====
/*
 * register map, field positions, reset values and timing counts of the
 * segment lcd driver.
 * assumes an 8-bit register port with a 6-bit byte address.
 */
`ifndef SLCD_REGS_VH
`define SLCD_REGS_VH

// display memory: 17 bytes at 0x00..0x10
`define SLCD_MEM_WORDS      17
`define SLCD_A_MEM_LAST     6'h10
`define SLCD_SEGS           33

// control and status registers
`define SLCD_A_CTRL         6'h20
`define SLCD_A_FDIV         6'h21
`define SLCD_A_CONTRAST     6'h22
`define SLCD_A_STATUS       6'h23
`define SLCD_A_PSEL         6'h24
`define SLCD_A_POUT         6'h2C
`define SLCD_PORT_LANES     6'h05
`define SLCD_PORT_TOP_LANE  3'h4

// ctrl fields
`define SLCD_CTRL_EN        0
`define SLCD_CTRL_MODE_LO   1
`define SLCD_CTRL_MODE_HI   2
`define SLCD_CTRL_FAST      3
`define SLCD_CTRL_MASK      8'h0F

// contrast fields
`define SLCD_CON_TAP_HI     3
`define SLCD_CON_EXT        4
`define SLCD_CON_MASK       8'h1F

// reset values
`define SLCD_CTRL_RST       8'h00
`define SLCD_FDIV_RST       8'h0F
`define SLCD_CON_RST        8'h08

// fast oscillator divided by 128: counter terminal value 127
`define SLCD_FAST_LAST      7'h7F
// scan walk: 17 reads plus one cycle of read latency
`define SLCD_SCAN_LAST      5'h11

// display modes; the code equals the index of the last backplane used
`define SLCD_MODE_STATIC    2'h0
`define SLCD_MODE_HALF      2'h1
`define SLCD_MODE_THIRD     2'h2
`define SLCD_MODE_QUARTER   2'h3

// drive level codes: v0 ground .. v3 full lcd voltage, v1/v2 bias taps
`define SLCD_LVL_V0         2'h0
`define SLCD_LVL_V1         2'h1
`define SLCD_LVL_V2         2'h2
`define SLCD_LVL_V3         2'h3

`endif

// ==== src/slcd_mem.v ====
/*
 * 17-byte display memory with one write port, one bus read port and one
 * scan read port; both read ports are registered.
 * assumes one clock, synchronous active-low reset, addresses below 17.
 */
`timescale 1ns/1ps
`include "slcd_regs.vh"

module slcd_mem (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       wr_i,
    input  wire [4:0] wr_addr_i,
    input  wire [7:0] wr_data_i,
    input  wire       rd_i,
    input  wire [4:0] rd_addr_i,
    input  wire       rd_alt_sel_i,
    input  wire [7:0] rd_alt_data_i,
    output wire [7:0] rd_data_o,
    input  wire [4:0] scan_addr_i,
    output wire [7:0] scan_data_o
);

    reg [7:0] mem_q [0:`SLCD_MEM_WORDS-1];
    reg [7:0] rd_data_q;
    reg [7:0] scan_data_q;

    always @(posedge clk_i) begin
        if (wr_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // read data stand for one cycle only, zero otherwise
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 8'h00;
        end else if (rd_i) begin
            rd_data_q <= rd_alt_sel_i ? rd_alt_data_i : mem_q[rd_addr_i];
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    // out-of-range scan address reads zero
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            scan_data_q <= 8'h00;
        end else if (scan_addr_i < `SLCD_MEM_WORDS) begin
            scan_data_q <= mem_q[scan_addr_i];
        end else begin
            scan_data_q <= 8'h00;
        end
    end

    assign rd_data_o   = rd_data_q;
    assign scan_data_o = scan_data_q;

endmodule

// ==== src/slcd_top.v ====
/*
 * segment lcd driver: register port, display memory scan, frame timing,
 * multiplexed backplane and element drive level codes, port-pin fallback.
 * assumes all inputs synchronous to REF_CLK_I (20 MHz); the analog bias
 * ladder turns each 2-bit level code into a voltage outside this block.
 */
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "slcd_regs.vh"

// Functional notes
// - drive 33 element lines and four backplane lines, multiplexed by mode.
// - an element lights when its element line opposes its active backplane.
// - element lines not used for the glass can act as plain port outputs.
// - element states come only from software-written display memory.
// - 17-byte display memory scanned each phase without software help.
// - unused display memory bits stay readable and writable storage.
// - four modes; static uses only the first backplane, no multiplexing.
// - half duty multiplexes first two backplanes with half bias levels.
// - third duty multiplexes first three backplanes with third bias levels.
// - quarter duty multiplexes all four backplanes with third bias levels.
// - scan clock from 32kHz input or fast oscillator divided by 128.
// - waveforms generated automatically at a software adjustable frame rate.
// - software sets contrast divider tap and supply or external reference.
module slcd_top (
    input  wire        REF_CLK_I,
    input  wire        RESETN_I,
    input  wire [5:0]  ADDR_I,
    input  wire [7:0]  WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output wire [7:0]  RDATA_O,
    input  wire        LCD_SLOW_CLK_I,
    output wire [65:0] SEG_LEVEL_O,
    output wire [7:0]  COM_LEVEL_O,
    output wire [32:0] SEG_PORT_MODE_O,
    output wire [3:0]  CONTRAST_TAP_O,
    output wire        CONTRAST_EXT_REF_O,
    output wire        BIAS_THIRD_O
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SCAN = 2'h1;
    localparam [1:0] ST_LOAD = 2'h2;

    reg  [7:0]  ctrl_q;
    reg  [7:0]  frame_div_q;
    reg  [7:0]  contrast_q;
    reg  [39:0] port_sel_q;
    reg  [39:0] port_out_q;
    reg         slow_q;
    reg         slow_prev_q;
    reg  [6:0]  fast_cnt_q;
    reg  [7:0]  div_cnt_q;
    reg  [1:0]  st_q;
    reg  [1:0]  st_d;
    reg  [4:0]  sidx_q;
    reg  [33:0] shadow_q;
    reg  [1:0]  scan_com_q;
    reg         scan_pol_q;
    reg  [32:0] disp_q;
    reg  [1:0]  com_q;
    reg         pol_q;
    reg         running_q;
    reg  [65:0] seg_lvl_q;
    reg  [65:0] seg_lvl_d;
    reg  [7:0]  com_lvl_q;
    reg  [7:0]  com_lvl_d;
    reg  [7:0]  rd_alt_d;
    reg  [7:0]  lane_byte;
    reg         bias_third_q;

    wire        lcd_en    = ctrl_q[`SLCD_CTRL_EN];
    wire [1:0]  mode      = ctrl_q[`SLCD_CTRL_MODE_HI:`SLCD_CTRL_MODE_LO];
    wire        fast_sel  = ctrl_q[`SLCD_CTRL_FAST];
    wire        wr_mem    = WR_I && (ADDR_I <= `SLCD_A_MEM_LAST);
    wire        rd_alt    = ADDR_I > `SLCD_A_MEM_LAST;
    wire [5:0]  psel_off  = ADDR_I - `SLCD_A_PSEL;
    wire [5:0]  pout_off  = ADDR_I - `SLCD_A_POUT;
    wire        psel_hit  = psel_off < `SLCD_PORT_LANES;
    wire        pout_hit  = pout_off < `SLCD_PORT_LANES;
    wire [7:0]  scan_data;
    wire        lcd_tick;
    wire        phase_adv;
    wire [4:0]  sbyte     = sidx_q - 5'h01;
    wire        third_bias = (mode == `SLCD_MODE_THIRD) || (mode == `SLCD_MODE_QUARTER);

    // element line level for a lit or dark crossing
    function [1:0] seg_level;
        input       on;
        input       pol;
        input       third;
        begin
            if (on) begin
                seg_level = pol ? `SLCD_LVL_V0 : `SLCD_LVL_V3;
            end else if (third) begin
                seg_level = pol ? `SLCD_LVL_V2 : `SLCD_LVL_V1;
            end else begin
                seg_level = pol ? `SLCD_LVL_V3 : `SLCD_LVL_V0;
            end
        end
    endfunction

    // backplane level, selected or idle
    function [1:0] com_level;
        input       sel;
        input       pol;
        input [1:0] md;
        begin
            if (sel || md == `SLCD_MODE_STATIC) begin
                com_level = pol ? `SLCD_LVL_V3 : `SLCD_LVL_V0;
            end else if (md == `SLCD_MODE_HALF) begin
                com_level = `SLCD_LVL_V1;
            end else begin
                com_level = pol ? `SLCD_LVL_V1 : `SLCD_LVL_V2;
            end
        end
    endfunction

    // byte for a port lane; the top lane holds only bit 32
    function [7:0] lane_data;
        input [2:0] lane;
        input [7:0] data;
        begin
            if (lane == `SLCD_PORT_TOP_LANE) begin
                lane_data = {7'h00, data[0]};
            end else begin
                lane_data = data;
            end
        end
    endfunction

    // spare bits behave as plain storage
    slcd_mem u_mem (
        .clk_i         (REF_CLK_I),
        .rst_n_i       (RESETN_I),
        .wr_i          (wr_mem),
        .wr_addr_i     (ADDR_I[4:0]),
        .wr_data_i     (WDATA_I),
        .rd_i          (RD_I),
        .rd_addr_i     (ADDR_I[4:0]),
        .rd_alt_sel_i  (rd_alt),
        .rd_alt_data_i (rd_alt_d),
        .rd_data_o     (RDATA_O),
        .scan_addr_i   (sidx_q),
        .scan_data_o   (scan_data)
    );

    // register writes; reserved bits are dropped
    always @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            ctrl_q      <= `SLCD_CTRL_RST;
            frame_div_q <= `SLCD_FDIV_RST;
            contrast_q  <= `SLCD_CON_RST;
            port_sel_q  <= 40'h00_0000_0000;
            port_out_q  <= 40'h00_0000_0000;
        end else if (WR_I) begin
            case (ADDR_I)
                `SLCD_A_CTRL: begin
                    ctrl_q <= WDATA_I & `SLCD_CTRL_MASK;
                end
                `SLCD_A_FDIV: begin
                    frame_div_q <= WDATA_I;
                end
                `SLCD_A_CONTRAST: begin
                    contrast_q <= WDATA_I & `SLCD_CON_MASK;
                end
                default: begin
                    if (psel_hit) begin
                        port_sel_q[{psel_off[2:0], 3'h0} +: 8] <= lane_data(psel_off[2:0], WDATA_I);
                    end
                    if (pout_hit) begin
                        port_out_q[{pout_off[2:0], 3'h0} +: 8] <= lane_data(pout_off[2:0], WDATA_I);
                    end
                end
            endcase
        end
    end

    // read mux for everything outside display memory
    always @* begin
        rd_alt_d  = 8'h00;
        lane_byte = 8'h00;
        case (ADDR_I)
            `SLCD_A_CTRL: begin
                rd_alt_d = ctrl_q;
            end
            `SLCD_A_FDIV: begin
                rd_alt_d = frame_div_q;
            end
            `SLCD_A_CONTRAST: begin
                rd_alt_d = contrast_q;
            end
            `SLCD_A_STATUS: begin
                rd_alt_d = {4'h0, running_q, pol_q, com_q};
            end
            default: begin
                if (psel_hit) begin
                    lane_byte = port_sel_q[{psel_off[2:0], 3'h0} +: 8];
                end else if (pout_hit) begin
                    lane_byte = port_out_q[{pout_off[2:0], 3'h0} +: 8];
                end
                rd_alt_d = lane_byte;
            end
        endcase
    end

    // scan clock source select
    // the slow input is taken as synchronous, so one flop suffices
    assign lcd_tick = fast_sel ? (fast_cnt_q == `SLCD_FAST_LAST) : (slow_q && !slow_prev_q);

    always @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            slow_q      <= 1'b0;
            slow_prev_q <= 1'b0;
            fast_cnt_q  <= 7'h00;
        end else begin
            slow_q      <= LCD_SLOW_CLK_I;
            slow_prev_q <= slow_q;
            fast_cnt_q  <= fast_cnt_q + 7'h01;
        end
    end

    // one backplane phase per frame_div+1 ticks
    assign phase_adv = lcd_en && lcd_tick && (div_cnt_q >= frame_div_q) && (st_q == ST_IDLE);

    always @(posedge REF_CLK_I) begin
        if (!RESETN_I || !lcd_en) begin
            div_cnt_q <= 8'h00;
        end else if (lcd_tick) begin
            if (div_cnt_q >= frame_div_q) begin
                div_cnt_q <= 8'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end

    // scan sequencer, a phase is far longer than the walk
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (phase_adv) begin
                    st_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (sidx_q == `SLCD_SCAN_LAST) begin
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge REF_CLK_I) begin
        if (!RESETN_I || !lcd_en) begin
            st_q       <= ST_IDLE;
            sidx_q     <= 5'h00;
            shadow_q   <= 34'h0_0000_0000;
            scan_com_q <= `SLCD_MODE_QUARTER;
            scan_pol_q <= 1'b1;
        end else begin
            st_q <= st_d;
            if (phase_adv) begin
                sidx_q <= 5'h00;
                // mode code is the last backplane index
                if (com_q >= mode) begin
                    scan_com_q <= 2'h0;
                    scan_pol_q <= ~pol_q;
                end else begin
                    scan_com_q <= com_q + 2'h1;
                    scan_pol_q <= pol_q;
                end
            end else if (st_q == ST_SCAN) begin
                sidx_q <= sidx_q + 5'h01;
                // low nibble even segment, high nibble odd segment
                if (sidx_q != 5'h00) begin
                    shadow_q[{sbyte, 1'b0}] <= scan_data[{1'b0, scan_com_q}];
                    shadow_q[{sbyte, 1'b1}] <= scan_data[{1'b1, scan_com_q}];
                end
            end
        end
    end

    // phase state shown on the pins; idle values mean the glass is dark
    always @(posedge REF_CLK_I) begin
        if (!RESETN_I || !lcd_en) begin
            disp_q    <= 33'h0_0000_0000;
            com_q     <= `SLCD_MODE_QUARTER;
            pol_q     <= 1'b1;
            running_q <= 1'b0;
        end else if (st_q == ST_LOAD) begin
            disp_q    <= shadow_q[32:0];
            com_q     <= scan_com_q;
            pol_q     <= scan_pol_q;
            running_q <= 1'b1;
        end
    end

    // element line levels
    integer i;
    always @* begin
        seg_lvl_d = 66'h0_0000_0000_0000_0000;
        for (i = 0; i < `SLCD_SEGS; i = i + 1) begin
            if (port_sel_q[i]) begin
                // port pin drives a full-swing logic level
                seg_lvl_d[2*i +: 2] = port_out_q[i] ? `SLCD_LVL_V3 : `SLCD_LVL_V0;
            end else if (running_q) begin
                // lit element opposes the selected backplane
                seg_lvl_d[2*i +: 2] = seg_level(disp_q[i], pol_q, third_bias);
            end
        end
    end

    // backplane levels; unused backplanes stay grounded
    integer c;
    always @* begin
        com_lvl_d = 8'h00;
        for (c = 0; c < 4; c = c + 1) begin
            if (running_q && (c <= mode)) begin
                com_lvl_d[2*c +: 2] = com_level(c == com_q, pol_q, mode);
            end
        end
    end

    // every drive line leaves a flop
    always @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            seg_lvl_q    <= 66'h0_0000_0000_0000_0000;
            com_lvl_q    <= 8'h00;
            bias_third_q <= 1'b0;
        end else begin
            seg_lvl_q    <= seg_lvl_d;
            com_lvl_q    <= com_lvl_d;
            bias_third_q <= third_bias;
        end
    end

    assign SEG_LEVEL_O        = seg_lvl_q;
    assign COM_LEVEL_O        = com_lvl_q;
    assign SEG_PORT_MODE_O    = port_sel_q[32:0];
    assign CONTRAST_TAP_O     = contrast_q[`SLCD_CON_TAP_HI:0];
    assign CONTRAST_EXT_REF_O = contrast_q[`SLCD_CON_EXT];
    assign BIAS_THIRD_O       = bias_third_q;

endmodule

// ==== dv/slcd_top_assertions.sv ====
/*
 * concurrent checks on the ports of slcd_top, attached by bind.
 * assumes one clock domain and the synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "slcd_regs.vh"

module slcd_top_assertions (
    input wire        REF_CLK_I,
    input wire        RESETN_I,
    input wire [5:0]  ADDR_I,
    input wire [7:0]  WDATA_I,
    input wire        WR_I,
    input wire        RD_I,
    input wire [7:0]  RDATA_O,
    input wire        LCD_SLOW_CLK_I,
    input wire [65:0] SEG_LEVEL_O,
    input wire [7:0]  COM_LEVEL_O,
    input wire [32:0] SEG_PORT_MODE_O,
    input wire [3:0]  CONTRAST_TAP_O,
    input wire        CONTRAST_EXT_REF_O,
    input wire        BIAS_THIRD_O
);
    // even bits flag element codes 1 or 2, which half bias never uses
    wire [65:0] seg_mix = SEG_LEVEL_O ^ {1'b0, SEG_LEVEL_O[65:1]};

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);

    chk_rd_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not zero outside read answer");
    chk_ctrl_readback: assert property (WR_I && ADDR_I == `SLCD_A_CTRL ##1 RD_I && ADDR_I == `SLCD_A_CTRL
        |=> RDATA_O == ($past(WDATA_I, 2) & `SLCD_CTRL_MASK)) else $error("control readback wrong");
    chk_mem_readback: assert property (WR_I && ADDR_I <= `SLCD_A_MEM_LAST ##1 RD_I && ADDR_I == $past(ADDR_I)
        |=> RDATA_O == $past(WDATA_I, 2)) else $error("display memory readback wrong");
    chk_unmapped_zero: assert property (RD_I && ((ADDR_I > 6'h10 && ADDR_I < 6'h20) || ADDR_I > 6'h30)
        |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
    chk_contrast_out: assert property (WR_I && ADDR_I == `SLCD_A_CONTRAST
        |=> {CONTRAST_EXT_REF_O, CONTRAST_TAP_O} == $past(WDATA_I[4:0])) else $error("contrast outputs wrong");
    chk_half_com_idle: assert property (!BIAS_THIRD_O |-> COM_LEVEL_O[7:4] == 4'h0)
        else $error("upper backplanes driven in static or half duty");
    chk_full_bias_seg: assert property (!BIAS_THIRD_O |-> (seg_mix & 66'h1_5555_5555_5555_5555) == 66'h0)
        else $error("mid level on element line under half bias");
    chk_level_hold: assert property ($changed(COM_LEVEL_O) |=> $stable(COM_LEVEL_O) [*8])
        else $error("backplane levels did not hold for the phase");

    cover property (BIAS_THIRD_O && COM_LEVEL_O[7:6] != 2'h0);
    cover property ($changed(COM_LEVEL_O) && !BIAS_THIRD_O);
    cover property (RD_I && ADDR_I == `SLCD_A_STATUS);
endmodule

bind slcd_top slcd_top_assertions slcd_top_assertions_inst (
    .REF_CLK_I, .RESETN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .LCD_SLOW_CLK_I,
    .SEG_LEVEL_O, .COM_LEVEL_O, .SEG_PORT_MODE_O, .CONTRAST_TAP_O, .CONTRAST_EXT_REF_O, .BIAS_THIRD_O
);

// ==== dv/slcd_glass.sv ====
/*
 * passive lcd glass: records which crossings saw full drive and the
 * dc sum, in sixths of the lcd voltage, of crossing line 0 / backplane 0,
 * one sample per level change.
 * assumes levels hold between changes, so one sample stands for a phase.
 */
`timescale 1ns/1ps

module slcd_glass (
    input  wire logic         clk_i,
    input  wire logic         clr_i,
    input  wire logic         third_i,
    input  wire logic [65:0]  seg_i,
    input  wire logic [7:0]   com_i,
    output logic      [131:0] shown_o,
    output int                dc_o
);
    logic [73:0] prev;

    // half bias ties both middle taps to half the lcd voltage
    function automatic int volt(input logic [1:0] lvl, input logic third);
        if (third)
            return 2 * int'(lvl);
        return (lvl == 2'h0) ? 0 : ((lvl == 2'h3) ? 6 : 3);
    endfunction

    always @(posedge clk_i) begin
        prev <= {com_i, seg_i};
        if (clr_i) begin
            shown_o <= '0;
            dc_o <= 0;
        end else if ({com_i, seg_i} !== prev) begin
            dc_o <= dc_o + volt(seg_i[1:0], third_i) - volt(com_i[1:0], third_i);
            for (int s = 0; s < 33; s++) begin
                for (int c = 0; c < 4; c++) begin
                    if ({seg_i[2*s +: 2], com_i[2*c +: 2]} inside {4'h3, 4'hC})
                        shown_o[4*s+c] <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== dv/segment_lcd_driver_tb.sv ====
/*
 * self-checking bench for slcd_top with a passive glass model.
 * assumes a 20 MHz clock; slow scan clock made here from a counter.
 */
`timescale 1ns/1ps
`include "slcd_regs.vh"

module segment_lcd_driver_tb;
    typedef struct packed {logic we; logic [5:0] a; logic [7:0] d; logic [7:0] e;} slcd_row_t;

    logic         ref_clk = 0, resetn = 0, wr = 0, rd = 0, slow_clk = 0, slow_run = 0, glass_clr = 0;
    logic [5:0]   addr = '0;
    logic [7:0]   wdata = '0, rdata;
    logic [65:0]  seg_level;
    logic [7:0]   com_level;
    logic [32:0]  seg_port_mode;
    logic [3:0]   contrast_tap, sc_cnt = '0;
    logic         contrast_ext, bias_third;
    logic [131:0] shown, exp_sh, msk;
    logic [7:0]   mem_img [17];
    int           dc, n, err_total = 0, total_checks = 0;
    slcd_row_t    rows [12] = '{'{0, 6'h20, 8'h00, 8'h00}, '{0, 6'h21, 8'h00, 8'h0F}, '{0, 6'h22, 8'h00, 8'h08},
        '{0, 6'h23, 8'h00, 8'h07}, '{1, 6'h00, 8'hA5, 8'hA5}, '{1, 6'h10, 8'h3C, 8'h3C}, '{1, 6'h22, 8'hFF, 8'h1F},
        '{1, 6'h23, 8'hFF, 8'h07}, '{1, 6'h15, 8'h55, 8'h00}, '{1, 6'h28, 8'hFF, 8'h01}, '{1, 6'h20, 8'hFE, 8'h0E},
        '{1, 6'h3F, 8'hAA, 8'h00}};

    slcd_top slcd_top_inst (.REF_CLK_I(ref_clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .LCD_SLOW_CLK_I(slow_clk), .SEG_LEVEL_O(seg_level), .COM_LEVEL_O(com_level),
        .SEG_PORT_MODE_O(seg_port_mode), .CONTRAST_TAP_O(contrast_tap), .CONTRAST_EXT_REF_O(contrast_ext),
        .BIAS_THIRD_O(bias_third));
    slcd_glass slcd_glass_inst (.clk_i(ref_clk), .clr_i(glass_clr), .third_i(bias_third), .seg_i(seg_level),
        .com_i(com_level), .shown_o(shown), .dc_o(dc));

    always #25 ref_clk = ~ref_clk;

    // slow source: one rising edge every 16 clocks, still when not running
    always @(posedge ref_clk) begin
        sc_cnt <= sc_cnt + 4'h1;
        slow_clk <= slow_run & sc_cnt[3];
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [131:0] seen, input logic [131:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        cyc(0, 1, a, 8'h00);
        cyc(0, 0, a, 8'h00);
        #1;
        check(rdata, e);
    endtask

    // bounded wait for the next drive level update; n counts the clocks
    task automatic wait_chg(output int n);
        logic [73:0] last;
        last = {com_level, seg_level};
        n = 0;
        while ({com_level, seg_level} === last && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("wrong value at %0t: no drive update", $time);
            conclude();
        end
    endtask

    function automatic logic [73:0] lv_exp(input logic [1:0] md, input logic p, input int cs);
        logic [73:0] r;
        r = '0;
        for (int s = 0; s < 33; s++)
            r[2*s +: 2] = mem_img[s/2][(s%2)*4+cs] ? (p ? 2'h0 : 2'h3) : (md < 2 ? (p ? 2'h3 : 2'h0) : (p ? 2'h2 : 2'h1));
        for (int c = 0; c <= md; c++)
            r[66+2*c +: 2] = (c == cs) ? (p ? 2'h3 : 2'h0) : (md == 1 ? 2'h1 : (p ? 2'h1 : 2'h2));
        return r;
    endfunction

    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1;
        #1;
        check({seg_level, com_level, seg_port_mode, contrast_tap, contrast_ext, bias_third}, 113'h8 << 2);
        foreach (rows[i]) begin
            if (rows[i].we)
                cyc(1, 0, rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        check({contrast_ext, contrast_tap}, 5'h1F);
        $display("test registers done");
        cyc(1, 0, `SLCD_A_PSEL, 8'h01);
        cyc(1, 0, `SLCD_A_PSEL + 6'h04, 8'h01);
        cyc(1, 0, `SLCD_A_POUT, 8'h01);
        cyc(1, 0, `SLCD_A_POUT + 6'h04, 8'h00);
        cyc(0, 0, 6'h00, 8'h00);
        repeat (300) @(posedge ref_clk);
        #1;
        check({seg_port_mode, seg_level}, {33'h1_0000_0001, 66'h3});
        cyc(1, 0, `SLCD_A_PSEL, 8'h00);
        cyc(1, 0, `SLCD_A_PSEL + 6'h04, 8'h00);
        cyc(1, 0, `SLCD_A_FDIV, 8'h00);
        for (int k = 0; k < 17; k++) begin
            mem_img[k] = {~k[3:0], k[3:0]};
            cyc(1, 0, k[5:0], mem_img[k]);
        end
        for (int k = 0; k < 17; k++)
            rd_chk(k[5:0], mem_img[k]);
        repeat (300) @(posedge ref_clk);
        $display("test port pins and memory done");
        for (int md = 0; md < 4; md++) begin
            // mode changes only while disabled, so bias and levels never disagree
            cyc(1, 0, `SLCD_A_CTRL, {4'h0, 1'b1, md[1:0], 1'b0});
            glass_clr <= 1;
            cyc(1, 0, `SLCD_A_CTRL, {4'h0, 1'b1, md[1:0], 1'b1});
            glass_clr <= 0;
            cyc(0, 0, 6'h00, 8'h00);
            for (int ph = 0; ph < 2*(md+1); ph++) begin
                wait_chg(n);
                if (ph > 0)
                    check(n, 128);
                check({bias_third, com_level, seg_level}, {md > 1, lv_exp(md[1:0], ph > md, ph % (md+1))});
            end
            @(posedge ref_clk);
            #1;
            check(dc, 0);
            exp_sh = '0;
            msk = '0;
            for (int s = 0; s < 33; s++) begin
                for (int c = 0; c <= md; c++) begin
                    msk[4*s+c] = 1'b1;
                    exp_sh[4*s+c] = mem_img[s/2][(s%2)*4+c];
                end
            end
            check(shown & msk, exp_sh);
            repeat (20) @(posedge ref_clk);
            cyc(1, 0, `SLCD_A_CTRL, {4'h0, 1'b1, md[1:0], 1'b0});
            cyc(0, 0, 6'h00, 8'h00);
            repeat (300) @(posedge ref_clk);
            $display("test mode %0d done", md);
        end
        cyc(1, 0, `SLCD_A_FDIV, 8'h01);
        cyc(1, 0, `SLCD_A_CTRL, 8'h00);
        cyc(1, 0, `SLCD_A_CTRL, 8'h01);
        cyc(0, 0, 6'h00, 8'h00);
        slow_run <= 1;
        wait_chg(n);
        wait_chg(n);
        check(n, 32);
        rd_chk(`SLCD_A_STATUS, 8'h0C);
        $display("test slow clock done");
        conclude();
    end
endmodule
